/* File: hw/cfg_pin_wake.sv */
`timescale 1ns/10ps
`default_nettype none

module cfg_pin_wake #(
   parameter int unsigned IDLE_CYCLES = cfg_pin_pkg::IDLE_CYC,
   parameter int unsigned LVL_30_CYCLES = cfg_pin_pkg::LVL_30_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ext_cfg_valid_i,
   input wire cfg_pin_pkg::cfg_t ext_cfg_i,
   input wire logic usb_suspend_i,
   input wire logic power_good_i,
   input wire logic tx_busy_i,
   input wire logic rx_busy_i,
   input wire logic tx_drv_en_i,
   input wire logic charger_det_i,
   input wire logic activity_i,
   input wire logic [2:0] gpio_out_i,
   input wire logic [2:0] gpio_oe_i,
   input wire logic ring_indicator_i,
   input wire logic io_pin_three_i,
   input wire logic hid_int_i,
   output logic io_pin_two_o,
   output logic io_pin_two_oe_o,
   output logic io_pin_a_o,
   output logic io_pin_a_oe_o,
   output logic io_pin_g_o,
   output logic io_pin_g_oe_o,
   output logic remote_wake_o,
   output logic interrupt_wake_o,
   output logic hid_int_o,
   output logic slow_clk_sel_o,
   output logic serial_num_en_o,
   output logic hid_present_o,
   output logic [6:0] hid_addr_o,
   output logic [15:0] hid_desc_addr_o,
   output logic [2:0] hid_opt_o,
   output logic hid_boot_subclass_o,
   output var cfg_pin_pkg::hid_proto_t hid_proto_o
);
   import cfg_pin_pkg::*;

   localparam int unsigned L1 = LVL_1_CYC;
   localparam int unsigned L5 = LVL_5_CYC;

   cfg_t cfg;
   logic cfg_loaded;
   logic [1:0] ring_sync;
   logic [1:0] int_sync;
   logic [1:0] hid_sync;
   logic ring_prev;
   logic int_prev;
   logic hid_prev;
   logic [CNT_W-1:0] int_lvl_cnt;
   logic [CNT_W-1:0] hid_lvl_cnt;
   logic [CNT_W-1:0] idle_cnt;
   logic [CNT_W-1:0] width_cyc;
   logic int_fire;
   logic hid_fire;
   logic ring_edge;
   logic [2:0] fn_val;
   logic [2:0] fn_oe;

   // ------------------------------------------------------------
   // Configuration load
   // ------------------------------------------------------------
   // Defaults apply at reset; a valid external image is taken once after it.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cfg <= CFG_DEFAULT;
         cfg_loaded <= 1'b0;
      end else if (ext_cfg_valid_i && !cfg_loaded) begin
         cfg <= ext_cfg_i;
         cfg_loaded <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   // Pins are asynchronous, so each goes through two flops first.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ring_sync <= 2'h3;
         int_sync <= 2'h0;
         hid_sync <= 2'h0;
         ring_prev <= 1'b1;
         int_prev <= 1'b0;
         hid_prev <= 1'b0;
      end else begin
         ring_sync <= {ring_sync[0], ring_indicator_i};
         int_sync <= {int_sync[0], io_pin_three_i};
         hid_sync <= {hid_sync[0], hid_int_i};
         ring_prev <= ring_sync[1];
         int_prev <= int_sync[1];
         hid_prev <= hid_sync[1];
      end
   end

   // ------------------------------------------------------------
   // Trigger detection
   // ------------------------------------------------------------
   // The level width is picked from the configured selection.
   always_comb begin
      case (cfg.int_width)
         LVL_W_1MS: width_cyc = CNT_W'(L1);
         LVL_W_5MS: width_cyc = CNT_W'(L5);
         default: width_cyc = CNT_W'(LVL_30_CYCLES);
      endcase
   end

   // Ring edge per configured direction.
   always_comb begin
      if (cfg.ring_wake_rising) begin
         ring_edge = ring_sync[1] && !ring_prev;
      end else begin
         ring_edge = !ring_sync[1] && ring_prev;
      end
   end

   // Level counters saturate one past the width so a held level fires once;
   // any release restarts the count from zero.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         int_lvl_cnt <= '0;
      end else if (int_sync[1] != (cfg.int_trig == TRIG_HIGH)) begin
         int_lvl_cnt <= '0;
      end else if (int_lvl_cnt <= width_cyc) begin
         int_lvl_cnt <= int_lvl_cnt + CNT_W'(1);
      end
   end

   // The HID target line uses the same width selection as pin three.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         hid_lvl_cnt <= '0;
      end else if (hid_sync[1] != (cfg.hid_int_trig == TRIG_HIGH)) begin
         hid_lvl_cnt <= '0;
      end else if (hid_lvl_cnt <= width_cyc) begin
         hid_lvl_cnt <= hid_lvl_cnt + CNT_W'(1);
      end
   end

   always_comb begin
      case (cfg.int_trig)
         TRIG_RISE: int_fire = int_sync[1] && !int_prev;
         TRIG_FALL: int_fire = !int_sync[1] && int_prev;
         default: int_fire = (int_lvl_cnt == width_cyc);
      endcase
      case (cfg.hid_int_trig)
         TRIG_RISE: hid_fire = hid_sync[1] && !hid_prev;
         TRIG_FALL: hid_fire = !hid_sync[1] && hid_prev;
         default: hid_fire = (hid_lvl_cnt == width_cyc);
      endcase
   end

   // One-cycle event pulses.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         interrupt_wake_o <= 1'b0;
         hid_int_o <= 1'b0;
         remote_wake_o <= 1'b0;
      end else begin
         interrupt_wake_o <= int_fire;
         hid_int_o <= hid_fire && (cfg.hid_addr != 7'h00);
         // Wake only while suspended, since the host ignores it otherwise.
         remote_wake_o <= cfg.remote_wake_en && usb_suspend_i &&
            ((cfg.ring_wake_en && ring_edge) || int_fire);
      end
   end

   // ------------------------------------------------------------
   // Idle clock switch
   // ------------------------------------------------------------
   // Any activity returns to the fast clock at once and restarts the count.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         idle_cnt <= '0;
         slow_clk_sel_o <= 1'b0;
      end else if (activity_i || !cfg.power_save_en) begin
         idle_cnt <= '0;
         slow_clk_sel_o <= 1'b0;
      end else if (idle_cnt < CNT_W'(IDLE_CYCLES)) begin
         idle_cnt <= idle_cnt + CNT_W'(1);
      end else begin
         slow_clk_sel_o <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Pin function mux
   // ------------------------------------------------------------
   // Function value and enable before the suspend override; index 0 is pin
   // two, 1 is pin A, 2 is pin G.
   always_comb begin
      fn_oe = 3'h7;
      case (cfg.pin_two_fn)
         PIN_TWO_GPIO: begin
            fn_val[0] = gpio_out_i[0];
            fn_oe[0] = gpio_oe_i[0];
         end
         PIN_TWO_PWR_GOOD: fn_val[0] = !power_good_i;
         PIN_TWO_TRANSMIT_ACTIVITY_LED: fn_val[0] = tx_busy_i;
         default: fn_val[0] = usb_suspend_i ~^ cfg.suspend_active_high;
      endcase
      case (cfg.pin_a_fn)
         PIN_A_GPIO: begin
            fn_val[1] = gpio_out_i[1];
            fn_oe[1] = gpio_oe_i[1];
         end
         PIN_A_TRANSMIT_ACTIVITY_LED: fn_val[1] = tx_busy_i;
         default: fn_val[1] = tx_drv_en_i;
      endcase
      case (cfg.pin_g_fn)
         PIN_G_GPIO: begin
            fn_val[2] = gpio_out_i[2];
            fn_oe[2] = gpio_oe_i[2];
         end
         PIN_G_PWR_GOOD: fn_val[2] = !power_good_i;
         PIN_G_RECEIVE_ACTIVITY_LED: fn_val[2] = rx_busy_i;
         default: begin
            fn_val[2] = charger_det_i ^ cfg.charger_active_low;
            fn_oe[2] = !cfg.charger_det_disable;
         end
      endcase
   end

   // Suspend pin state override, registered so every pin comes from a flop.
   logic [2:0] pin_val;
   logic [2:0] pin_oe;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               pin_val[gi] <= 1'b0;
               pin_oe[gi] <= 1'b0;
            end else if (usb_suspend_i && cfg.susp_state != SUSP_KEEP) begin
               pin_val[gi] <= (cfg.susp_state == SUSP_HIGH);
               pin_oe[gi] <= (cfg.susp_state != SUSP_TRISTATE);
            end else begin
               pin_val[gi] <= fn_val[gi];
               pin_oe[gi] <= fn_oe[gi];
            end
         end
      end
   endgenerate

   assign io_pin_two_o = pin_val[0];
   assign io_pin_two_oe_o = pin_oe[0];
   assign io_pin_a_o = pin_val[1];
   assign io_pin_a_oe_o = pin_oe[1];
   assign io_pin_g_o = pin_val[2];
   assign io_pin_g_oe_o = pin_oe[2];

   // ------------------------------------------------------------
   // Descriptor settings
   // ------------------------------------------------------------
   // Registered copies for the USB and I2C engines.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         serial_num_en_o <= 1'b0;
         hid_present_o <= 1'b0;
         hid_addr_o <= 7'h00;
         hid_desc_addr_o <= 16'h0000;
         hid_opt_o <= 3'h0;
         hid_boot_subclass_o <= 1'b0;
         hid_proto_o <= HID_PROTO_NONE;
      end else begin
         serial_num_en_o <= cfg.serial_num_en;
         hid_present_o <= (cfg.hid_addr != 7'h00);
         hid_addr_o <= cfg.hid_addr;
         hid_desc_addr_o <= cfg.hid_desc_addr;
         hid_opt_o <= cfg.hid_opt;
         hid_boot_subclass_o <= cfg.hid_boot_subclass;
         hid_proto_o <= cfg.hid_proto;
      end
   end

endmodule

`default_nettype wire

/* File: hw/cfg_pin_pkg.sv */
package cfg_pin_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned LVL_WIDTH_1_MS = 1;
   localparam int unsigned LVL_WIDTH_5_MS = 5;
   localparam int unsigned LVL_WIDTH_30_MS = 30;
   localparam int unsigned IDLE_TIME_S = 5;
   localparam int unsigned SLOW_CLK_HZ = 30000;
   localparam int unsigned LVL_1_CYC = CLK_HZ / 1000 * LVL_WIDTH_1_MS;
   localparam int unsigned LVL_5_CYC = CLK_HZ / 1000 * LVL_WIDTH_5_MS;
   localparam int unsigned LVL_30_CYC = CLK_HZ / 1000 * LVL_WIDTH_30_MS;
   localparam int unsigned IDLE_CYC = CLK_HZ * IDLE_TIME_S;
   localparam int unsigned CNT_W = 26;

   // ------------------------------------------------------------
   // Enumerations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      TRIG_RISE = 2'h0,
      TRIG_FALL = 2'h1,
      TRIG_HIGH = 2'h2,
      TRIG_LOW = 2'h3
   } trig_t;

   typedef enum logic [1:0] {
      LVL_W_1MS = 2'h0,
      LVL_W_5MS = 2'h1,
      LVL_W_30MS = 2'h2
   } lvl_width_t;

   typedef enum logic [1:0] {
      PIN_TWO_GPIO = 2'h0,
      PIN_TWO_PWR_GOOD = 2'h1,
      PIN_TWO_TRANSMIT_ACTIVITY_LED = 2'h2,
      PIN_TWO_SUSPEND = 2'h3
   } pin_two_fn_t;

   typedef enum logic [1:0] {
      PIN_A_GPIO = 2'h0,
      PIN_A_TRANSMIT_ACTIVITY_LED = 2'h1,
      PIN_A_TX_DRV_EN = 2'h2
   } pin_a_fn_t;

   typedef enum logic [1:0] {
      PIN_G_GPIO = 2'h0,
      PIN_G_PWR_GOOD = 2'h1,
      PIN_G_RECEIVE_ACTIVITY_LED = 2'h2,
      PIN_G_CHARGER = 2'h3
   } pin_g_fn_t;

   typedef enum logic [1:0] {
      SUSP_KEEP = 2'h0,
      SUSP_TRISTATE = 2'h1,
      SUSP_LOW = 2'h2,
      SUSP_HIGH = 2'h3
   } susp_state_t;

   typedef enum logic [1:0] {
      HID_PROTO_NONE = 2'h0,
      HID_PROTO_KEYBOARD = 2'h1,
      HID_PROTO_MOUSE = 2'h2
   } hid_proto_t;

   // ------------------------------------------------------------
   // Configuration record
   // ------------------------------------------------------------
   typedef struct packed {
      logic remote_wake_en;
      logic serial_num_en;
      logic suspend_active_high;
      logic ring_wake_en;
      logic ring_wake_rising;
      pin_two_fn_t pin_two_fn;
      pin_a_fn_t pin_a_fn;
      pin_g_fn_t pin_g_fn;
      logic charger_det_disable;
      logic charger_active_low;
      trig_t int_trig;
      lvl_width_t int_width;
      logic power_save_en;
      susp_state_t susp_state;
      logic [6:0] hid_addr;
      logic [15:0] hid_desc_addr;
      trig_t hid_int_trig;
      logic [2:0] hid_opt;
      logic hid_boot_subclass;
      hid_proto_t hid_proto;
   } cfg_t;

   localparam cfg_t CFG_DEFAULT = '{
      remote_wake_en: 1'b1,
      serial_num_en: 1'b0,
      suspend_active_high: 1'b0,
      ring_wake_en: 1'b0,
      ring_wake_rising: 1'b0,
      pin_two_fn: PIN_TWO_SUSPEND,
      pin_a_fn: PIN_A_TX_DRV_EN,
      pin_g_fn: PIN_G_CHARGER,
      charger_det_disable: 1'b0,
      charger_active_low: 1'b0,
      int_trig: TRIG_HIGH,
      int_width: LVL_W_30MS,
      power_save_en: 1'b1,
      susp_state: SUSP_KEEP,
      hid_addr: 7'h00,
      hid_desc_addr: 16'h0000,
      hid_int_trig: TRIG_RISE,
      hid_opt: 3'h0,
      hid_boot_subclass: 1'b0,
      hid_proto: HID_PROTO_NONE
   };

   // Bit positions of the optional request flags in hid_opt.
   localparam int unsigned OPT_IDLE = 0;
   localparam int unsigned OPT_PROTOCOL = 1;
   localparam int unsigned OPT_POWER = 2;

endpackage

/* File: tb/cfg_pin_wake_properties.sv */
`timescale 1ns/10ps
`default_nettype none

// ----
// Port checker
// ----
module cfg_pin_wake_properties #(
   parameter int unsigned IDLE_CYCLES = 100
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic activity_i,
   input wire logic usb_suspend_i,
   input wire logic remote_wake_o,
   input wire logic interrupt_wake_o,
   input wire logic hid_int_o,
   input wire logic slow_clk_sel_o,
   input wire logic hid_present_o,
   input wire logic [6:0] hid_addr_o
);
   import cfg_pin_pkg::*;
   logic [31:0] quiet;

   // Quiet cycles since activity; wide enough that it never wraps in a run.
   always_ff @(posedge clk_i) begin
      if (reset_i || activity_i) begin
         quiet <= 32'h0;
      end else begin
         quiet <= quiet + 32'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   sequence s_busy;
      activity_i;
   endsequence
   sequence s_slow_up;
      $rose(slow_clk_sel_o);
   endsequence
   property p_wake_pulse;
      remote_wake_o |=> !remote_wake_o;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
   property p_wake_susp;
      remote_wake_o |-> $past(usb_suspend_i) || $past(usb_suspend_i, 2);
   endproperty
   a_wake_susp: assert property (p_wake_susp) else $error("wake while awake");
   property p_irq_pulse;
      interrupt_wake_o |=> !interrupt_wake_o;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("irq pulse too long");
   property p_hid_pulse;
      hid_int_o |=> !hid_int_o;
   endproperty
   a_hid_pulse: assert property (p_hid_pulse) else $error("hid pulse too long");
   property p_hid_gate;
      hid_int_o |-> hid_present_o;
   endproperty
   a_hid_gate: assert property (p_hid_gate) else $error("hid irq with no target");
   property p_present;
      hid_present_o == (hid_addr_o != 7'h00);
   endproperty
   a_present: assert property (p_present) else $error("presence not from address");
   property p_slow_off;
      s_busy |=> !slow_clk_sel_o;
   endproperty
   a_slow_off: assert property (p_slow_off) else $error("slow clock kept when busy");
   property p_slow_on;
      s_slow_up |-> quiet >= IDLE_CYCLES;
   endproperty
   a_slow_on: assert property (p_slow_on) else $error("slow clock too early");
endmodule

bind cfg_pin_wake cfg_pin_wake_properties #(.IDLE_CYCLES(IDLE_CYCLES)) u_props (
   .clk_i, .reset_i, .activity_i, .usb_suspend_i, .remote_wake_o, .interrupt_wake_o,
   .hid_int_o, .slow_clk_sel_o, .hid_present_o, .hid_addr_o
);
`default_nettype wire

/* File: tb/far_side_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----
// Ring line, wake source and HID target interrupt
// ----
module far_side_model (
   input wire logic clk_i,
   input wire logic wake_i,
   input wire logic irq_i,
   input wire logic hid_irq_i,
   output logic ring_o,
   output logic pin_three_o,
   output logic hid_line_o
);
   int wake_cnt = 0;
   int irq_cnt = 0;
   int hid_cnt = 0;

   // The ring line rests high, the others low.
   initial begin
      ring_o = 1'h1;
      pin_three_o = 1'h0;
      hid_line_o = 1'h0;
   end

   // Lines move just after an edge, as asynchronous sources may.
   task automatic put(input int n, input logic v);
      @(posedge clk_i);
      case (n)
         0: ring_o <= v;
         1: pin_three_o <= v;
         default: hid_line_o <= v;
      endcase
   endtask

   // Pulses stand one cycle, so one sample per edge counts each once.
   always @(posedge clk_i) begin
      wake_cnt <= wake_cnt + int'(wake_i);
      irq_cnt <= irq_cnt + int'(irq_i);
      hid_cnt <= hid_cnt + int'(hid_irq_i);
   end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

// ----
// Testbench
// ----
module testbench;
   import cfg_pin_pkg::*;
   localparam logic [3:0] E_TWO = 4'h9, E_G = 4'hD, E_OE = 4'hD;
   logic clk_i = 1'h0, reset_i = 1'h1, ext_cfg_valid_i = 1'h0;
   cfg_t ext_cfg_i = CFG_DEFAULT, c;
   logic usb_suspend_i = 1'h0, power_good_i = 1'h1, tx_busy_i = 1'h0, rx_busy_i = 1'h0;
   logic tx_drv_en_i = 1'h1, charger_det_i = 1'h1, activity_i = 1'h0;
   logic [2:0] gpio_out_i = 3'h0, gpio_oe_i = 3'h0;
   wire logic ring_indicator_i, io_pin_three_i, hid_int_i;
   logic io_pin_two_o, io_pin_two_oe_o, io_pin_a_o, io_pin_a_oe_o, io_pin_g_o, io_pin_g_oe_o;
   logic remote_wake_o, interrupt_wake_o, hid_int_o, slow_clk_sel_o, serial_num_en_o;
   logic hid_present_o, hid_boot_subclass_o;
   logic [6:0] hid_addr_o;
   logic [15:0] hid_desc_addr_o;
   logic [2:0] hid_opt_o;
   hid_proto_t hid_proto_o;
   int error_cnt = 0, comparisons = 0, t, n0, w0, h0;

   // Short counts keep the idle timer and the 30 ms level timer within a brief run.
   cfg_pin_wake #(.IDLE_CYCLES(100), .LVL_30_CYCLES(50)) u_cfg_pin_wake (
      .clk_i, .reset_i, .ext_cfg_valid_i, .ext_cfg_i, .usb_suspend_i, .power_good_i,
      .tx_busy_i, .rx_busy_i, .tx_drv_en_i, .charger_det_i, .activity_i, .gpio_out_i,
      .gpio_oe_i, .ring_indicator_i, .io_pin_three_i, .hid_int_i, .io_pin_two_o,
      .io_pin_two_oe_o, .io_pin_a_o, .io_pin_a_oe_o, .io_pin_g_o, .io_pin_g_oe_o,
      .remote_wake_o, .interrupt_wake_o, .hid_int_o, .slow_clk_sel_o, .serial_num_en_o,
      .hid_present_o, .hid_addr_o, .hid_desc_addr_o, .hid_opt_o, .hid_boot_subclass_o,
      .hid_proto_o
   );
   far_side_model u_far_side_model (.clk_i, .wake_i(remote_wake_o), .irq_i(interrupt_wake_o),
      .hid_irq_i(hid_int_o), .ring_o(ring_indicator_i), .pin_three_o(io_pin_three_i),
      .hid_line_o(hid_int_i));

   // Free-running system clock.
   initial begin
      forever #50 clk_i = ~clk_i;
   end

   task finish_test();
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s exp %h got %h", n, e, g);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // Sampling 1 ns after the edge lets registered outputs settle first.
   task look(input int n);
      tick(n);
      #1;
   endtask

   task automatic wait_ev(input int w, input int b, output int k);
      logic [3:0] ev;
      k = 0;
      do begin
         look(1);
         k++;
         ev = {slow_clk_sel_o, hid_int_o, remote_wake_o, interrupt_wake_o};
      end while (ev[w] !== 1'h1 && k < b);
      if (ev[w] !== 1'h1) begin
         error_cnt++;
         $display("Error event %0d exp 1 got 0", w);
         finish_test();
      end
   endtask

   // Reset for 16 cycles; the record is offered with the reset and taken as it lifts.
   task rst(input logic v, input cfg_t r);
      reset_i <= 1'h1;
      ext_cfg_valid_i <= v;
      ext_cfg_i <= r;
      tick(16);
      reset_i <= 1'h0;
   endtask

   initial begin
      rst(1'h0, CFG_DEFAULT);
      look(4);
      chk("serial", 0, serial_num_en_o);
      chk("present", 0, {hid_present_o, hid_addr_o});
      chk("desc", 0, hid_desc_addr_o);
      chk("opt", 0, {hid_opt_o, hid_boot_subclass_o, hid_proto_o});
      chk("pins", 6'h3F, {io_pin_two_o, io_pin_two_oe_o, io_pin_a_o, io_pin_a_oe_o,
         io_pin_g_o, io_pin_g_oe_o});
      tick(1);
      usb_suspend_i <= 1'h1;
      look(3);
      chk("susp two", 0, io_pin_two_o);
      w0 = u_far_side_model.wake_cnt;
      h0 = u_far_side_model.hid_cnt;
      n0 = u_far_side_model.irq_cnt;
      u_far_side_model.put(0, 1'h0);
      u_far_side_model.put(2, 1'h1);
      u_far_side_model.put(1, 1'h1);
      look(30);
      u_far_side_model.put(1, 1'h0);
      look(5);
      chk("no ring", w0, u_far_side_model.wake_cnt);
      chk("no hid", h0, u_far_side_model.hid_cnt);
      chk("no early irq", n0, u_far_side_model.irq_cnt);
      u_far_side_model.put(1, 1'h1);
      wait_ev(0, 80, t);
      chk("level width", 1, t >= 50 && t <= 62);
      look(60);
      chk("irq once", n0 + 1, u_far_side_model.irq_cnt);
      chk("wake", w0 + 1, u_far_side_model.wake_cnt);
      chk("slow", 1, slow_clk_sel_o);
      u_far_side_model.put(1, 1'h0);
      activity_i <= 1'h1;
      tick(1);
      activity_i <= 1'h0;
      look(1);
      chk("slow off", 0, slow_clk_sel_o);
      wait_ev(3, 130, t);
      chk("idle", 1, t >= 99 && t <= 106);
      tick(1);
      c = CFG_DEFAULT;
      c.serial_num_en = 1'h1;
      c.ring_wake_en = 1'h1;
      c.ring_wake_rising = 1'h1;
      c.pin_two_fn = PIN_TWO_TRANSMIT_ACTIVITY_LED;
      c.pin_a_fn = PIN_A_GPIO;
      c.charger_det_disable = 1'h1;
      c.int_trig = TRIG_RISE;
      c.power_save_en = 1'h0;
      c.hid_addr = 7'h2A;
      c.hid_desc_addr = 16'h1234;
      c.hid_int_trig = TRIG_FALL;
      c.hid_opt = 3'h5;
      c.hid_boot_subclass = 1'h1;
      c.hid_proto = HID_PROTO_MOUSE;
      tx_busy_i <= 1'h1;
      gpio_out_i <= 3'h2;
      gpio_oe_i <= 3'h2;
      rst(1'h1, c);
      look(4);
      chk("serial", 1, serial_num_en_o);
      chk("addr", 8'hAA, {hid_present_o, hid_addr_o});
      chk("desc", 16'h1234, hid_desc_addr_o);
      chk("opt", 6'h2E, {hid_opt_o, hid_boot_subclass_o, hid_proto_o});
      chk("pins", 5'h1E, {io_pin_two_o, io_pin_two_oe_o, io_pin_a_o, io_pin_a_oe_o,
         io_pin_g_oe_o});
      u_far_side_model.put(0, 1'h1);
      wait_ev(1, 10, t);
      u_far_side_model.put(1, 1'h1);
      wait_ev(0, 10, t);
      u_far_side_model.put(2, 1'h0);
      wait_ev(2, 10, t);
      look(120);
      chk("no slow", 0, slow_clk_sel_o);
      for (int i = 0; i < 4; i++) begin
         tick(1);
         c = CFG_DEFAULT;
         c.pin_two_fn = pin_two_fn_t'(i);
         c.pin_g_fn = pin_g_fn_t'(i);
         c.susp_state = susp_state_t'(i);
         c.charger_active_low = 1'h1;
         c.int_trig = trig_t'(i);
         c.hid_int_trig = trig_t'(i);
         c.hid_addr = 7'h11;
         usb_suspend_i <= 1'h0;
         gpio_out_i <= 3'h5;
         gpio_oe_i <= 3'h7;
         tx_busy_i <= 1'h0;
         rx_busy_i <= 1'h1;
         charger_det_i <= 1'h0;
         u_far_side_model.put(1, i[0]);
         u_far_side_model.put(2, i[0]);
         rst(1'h1, c);
         look(4);
         chk("two fn", E_TWO[i], io_pin_two_o);
         chk("g fn", E_G[i], io_pin_g_o);
         u_far_side_model.put(1, ~i[0]);
         wait_ev(0, 70, t);
         chk("irq trig", 1, (i < 2) ? (t <= 8) : (t >= 50));
         u_far_side_model.put(2, ~i[0]);
         wait_ev(2, 70, t);
         chk("hid trig", 1, (i < 2) ? (t <= 8) : (t >= 50));
         tick(1);
         usb_suspend_i <= 1'h1;
         look(3);
         chk("susp oe", {3{E_OE[i]}}, {io_pin_two_oe_o, io_pin_a_oe_o, io_pin_g_oe_o});
         if (i != 1) begin
            chk("susp val", {2{E_TWO[i]}}, {io_pin_two_o, io_pin_a_o});
         end
      end
      // Short width, wake refused, and the polarities and functions left over.
      // The ring line is high here, so the falling edge below is a real one.
      tick(1);
      c = CFG_DEFAULT;
      c.remote_wake_en = 1'h0;
      c.ring_wake_en = 1'h1;
      c.suspend_active_high = 1'h1;
      c.pin_a_fn = PIN_A_TRANSMIT_ACTIVITY_LED;
      c.int_width = LVL_W_1MS;
      tx_busy_i <= 1'h1;
      tx_drv_en_i <= 1'h0;
      rst(1'h1, c);
      look(4);
      chk("susp high", 1, io_pin_two_o);
      chk("a transmit_activity_led", 1, io_pin_a_o);
      w0 = u_far_side_model.wake_cnt;
      n0 = u_far_side_model.irq_cnt;
      u_far_side_model.put(0, 1'h0);
      u_far_side_model.put(1, 1'h1);
      wait_ev(0, LVL_1_CYC + 20, t);
      chk("1ms width", 1, t >= LVL_1_CYC && t <= LVL_1_CYC + 12);
      look(2);
      chk("irq 1ms", n0 + 1, u_far_side_model.irq_cnt);
      chk("wake off", w0, u_far_side_model.wake_cnt);
      finish_test();
   end
endmodule
`default_nettype wire
